// ---- common/fdrhc_pkg.sv ----
// Shared constants and types for the deep power-down resume and pause-pin control block
package fdrhc_pkg;

  // Opcode that wakes the device, also the identifier-read form
  localparam logic [7:0] FDRHC_OP_RESUME = 8'hab;
  // Index of the last bit in one serial byte, and dummy bytes before the identifier
  localparam logic [2:0] FDRHC_BIT_LAST = 3'h7;
  localparam logic [2:0] FDRHC_DUMMY_BYTES = 3'h3;
  // Byte count at which the identifier starts to shift out
  localparam logic [2:0] FDRHC_ID_START = 3'h4;
  // Identifier bit index that opens and reopens each output byte
  localparam logic [2:0] FDRHC_ID_MSB = 3'h7;
  // Synchroniser depth for pins from outside the clock domain
  localparam int FDRHC_SYNC_STAGES = 3;
  // Pin reset values: chip select, pause and protect idle high
  localparam logic [4:0] FDRHC_PIN_RST = 5'h1c;

  // Power mode of the device
  typedef enum logic {
    MODE_STANDBY,
    MODE_DPD
  } fdrhc_mode_t;

  // Serial pins as seen by the device, active-low ones marked N
  typedef struct packed {
    logic csN;
    logic pauseN;
    logic wpN;
    logic sck;
    logic si;
  } fdrhc_pins_t;

  // Whole state of the control block
  typedef struct packed {
    fdrhc_mode_t mode;
    logic armed;
    logic hold;
    logic csPrev;
    logic sckPrev;
    logic [2:0] bitMod;
    logic [2:0] byteCnt;
    logic [7:0] shiftIn;
    logic idPhase;
    logic [2:0] idIdx;
    logic soDrive;
    logic soOut;
    logic soOe;
    logic pauseOut;
    logic pauseOe;
    logic cmdValid;
    logic [7:0] cmdByte;
    logic resumeDone;
    logic abortOp;
    logic welClear;
    logic wpLvl;
    logic busy;
  } fdrhc_state_t;

  localparam fdrhc_state_t FDRHC_ST_RST = '{
    mode: MODE_STANDBY, armed: 1'b0, hold: 1'b0, csPrev: 1'b1, sckPrev: 1'b0,
    bitMod: 3'h0, byteCnt: 3'h0, shiftIn: 8'h00, idPhase: 1'b0, idIdx: FDRHC_ID_MSB,
    soDrive: 1'b0, soOut: 1'b0, soOe: 1'b0, pauseOut: 1'b0, pauseOe: 1'b0,
    cmdValid: 1'b0, cmdByte: 8'h00, resumeDone: 1'b0, abortOp: 1'b0,
    welClear: 1'b0, wpLvl: 1'b1, busy: 1'b0};

endpackage : fdrhc_pkg

// ---- src/fdrhc_pin_sync.sv ----
// Three-stage synchroniser with agreement filter for asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module fdrhc_pin_sync #(
  parameter int W = 5,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic rstN,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] pinLvl
);

  // Per-bit chain; first stage feeds only the second
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic s1_q;
    logic s2_q;
    logic s3_q;
    always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
        s1_q <= RST_VAL[i];
        s2_q <= RST_VAL[i];
        s3_q <= RST_VAL[i];
        pinLvl[i] <= RST_VAL[i];
      end else begin
        s1_q <= pinIn[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
        // Change accepted only once stages two and three agree
        if (s2_q == s3_q) begin
          pinLvl[i] <= s3_q;
        end
      end
    end
  end

endmodule : fdrhc_pin_sync
`default_nettype wire

// ---- src/flash_dpd_resume_hold_ctrl.sv ----
// Deep power-down resume, identifier read and pause-pin control of a serial flash
// Functional notes
// - In deep power-down only opcode ABh is decoded; all else ignored.
// - After full resume opcode, extra whole bytes ignored; chip-select rise enters standby.
// - Early chip-select rise or non-byte bit count aborts; stays powered down.
// - Opcode ABh plus three dummies; identifier shifts MSB first on falling clock.
// - Single identifier byte repeats from bit 7 while selected and clocked.
// - Identifier read also accepted in standby; no enforced high interval after.
// - Pause stops only the serial transfer; self-timed operations continue.
// - Quad-enable set turns the pause pin into a data pin.
// - Pause enters only while selected, asserted in clock low phase.
// - Pause asserted during clock high waits for next low phase.
// - During pause output floats; data input and clock ignored.
// - Write-protect input still honoured during pause.
// - Pause release takes effect in a clock low phase only.
// - Chip-select rise during pause aborts and clears write-enable latch.
`timescale 1ns/1ps
`default_nettype none
module flash_dpd_resume_hold_ctrl
  import fdrhc_pkg::*;
#(
  parameter logic [7:0] DEV_ID = 8'h5a  // Arbitrary identifier value
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire fdrhc_pins_t spiPins,
  input wire logic quadEnableBit,
  input wire logic quadDataOut,
  input wire logic quadDataOe,
  input wire logic busyIn,
  input wire logic dpdEnterReq,
  output logic soOut,
  output logic soOe,
  output logic pausePinOut,
  output logic pausePinOe,
  output logic inDeepPowerDown,
  output logic inHold,
  output logic cmdValid,
  output logic [7:0] cmdByte,
  output logic resumeDone,
  output logic abortOp,
  output logic writeEnableLatchBitClear,
  output logic wpLevel,
  output logic busyOut
);

  logic [1:0] rstPipe_q;
  logic rstN;
  fdrhc_pins_t pinLvl;
  logic [4:0] pinLvlRaw;
  fdrhc_state_t st_q;
  fdrhc_state_t st_d;
  logic csRise;
  logic sckRise;
  logic sckFall;
  logic pauseAsserted;
  logic active;
  logic [7:0] byteIn;

  // Reset released through two flops so release is synchronous
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rstPipe_q <= 2'h0;
    end else begin
      rstPipe_q <= {rstPipe_q[0], 1'b1};
    end
  end
  assign rstN = rstPipe_q[1];

  // All pins come from the host's domain
  fdrhc_pin_sync #(
    .W(5),
    .RST_VAL(FDRHC_PIN_RST)
  ) u_sync (
    .clk_sys(clk_sys),
    .rstN(rstN),
    .pinIn(spiPins),
    .pinLvl(pinLvlRaw)
  );
  assign pinLvl = fdrhc_pins_t'(pinLvlRaw);

  // Edge detection on filtered levels
  assign csRise = pinLvl.csN & ~st_q.csPrev;
  assign sckRise = pinLvl.sck & ~st_q.sckPrev;
  assign sckFall = ~pinLvl.sck & st_q.sckPrev;
  assign pauseAsserted = ~quadEnableBit & ~pinLvl.pauseN;
  assign byteIn = {st_q.shiftIn[6:0], pinLvl.si};

  // Next-state logic
  always_comb begin
    st_d = st_q;
    st_d.cmdValid = 1'b0;
    st_d.resumeDone = 1'b0;
    st_d.abortOp = 1'b0;
    st_d.welClear = 1'b0;
    st_d.csPrev = pinLvl.csN;
    st_d.sckPrev = pinLvl.sck;
    st_d.wpLvl = pinLvl.wpN;
    st_d.busy = busyIn;
    // Pause pin as data line in quad mode; control pin otherwise
    st_d.pauseOut = quadEnableBit & quadDataOut;
    st_d.pauseOe = quadEnableBit & quadDataOe;

    // Pause cleared at once by deselect or quad mode; otherwise changes only in clock low phase
    if (pinLvl.csN || quadEnableBit) begin
      st_d.hold = 1'b0;
    end else if (!pinLvl.sck) begin
      st_d.hold = pauseAsserted;
    end
    active = ~pinLvl.csN & ~st_d.hold;

    // Input bits on rising clock; paused clock edges ignored
    if (active && sckRise) begin
      st_d.shiftIn = byteIn;
      st_d.bitMod = st_q.bitMod + 3'h1;
      if (st_q.bitMod == FDRHC_BIT_LAST) begin
        if (st_q.byteCnt == 3'h0) begin
          unique case (st_q.mode)
            MODE_DPD: begin
              st_d.armed = (byteIn == FDRHC_OP_RESUME);
            end
            MODE_STANDBY: begin
              st_d.armed = (byteIn == FDRHC_OP_RESUME);
              if (byteIn != FDRHC_OP_RESUME) begin
                st_d.cmdValid = 1'b1;
                st_d.cmdByte = byteIn;
              end
            end
          endcase
        end
        // Bytes past the identifier start are not counted
        if (st_q.byteCnt != FDRHC_ID_START) begin
          st_d.byteCnt = st_q.byteCnt + 3'h1;
        end
        if (st_q.armed && st_q.byteCnt == FDRHC_DUMMY_BYTES) begin
          st_d.idPhase = 1'b1;
        end
      end
    end

    // Identifier out on falling clock, MSB first, wrapping
    if (active && sckFall && st_q.idPhase) begin
      st_d.soDrive = 1'b1;
      st_d.soOut = DEV_ID[st_q.idIdx];
      st_d.idIdx = st_q.idIdx - 3'h1;
    end

    // Chip-select rise closes the frame
    if (csRise) begin
      if (pauseAsserted) begin
        st_d.abortOp = 1'b1;
        st_d.welClear = 1'b1;
      end else if (st_q.mode == MODE_DPD && st_q.armed && st_q.bitMod == 3'h0) begin
        st_d.mode = MODE_STANDBY;
        st_d.resumeDone = 1'b1;
      end
      // Partial opcode or odd bit count leaves the mode as it was
      st_d.armed = 1'b0;
      st_d.bitMod = 3'h0;
      st_d.byteCnt = 3'h0;
      st_d.idPhase = 1'b0;
      st_d.idIdx = FDRHC_ID_MSB;
      st_d.soDrive = 1'b0;
    end

    // Entry from elsewhere only when deselected and idle
    if (dpdEnterReq && pinLvl.csN && !csRise && !busyIn && st_q.mode == MODE_STANDBY) begin
      st_d.mode = MODE_DPD;
    end

    // Output floats while paused, returns after release
    st_d.soOe = st_d.soDrive & ~st_d.hold;
  end

  // State register
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      st_q <= FDRHC_ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register
  assign soOut = st_q.soOut;
  assign soOe = st_q.soOe;
  assign pausePinOut = st_q.pauseOut;
  assign pausePinOe = st_q.pauseOe;
  assign inDeepPowerDown = (st_q.mode == MODE_DPD);
  assign inHold = st_q.hold;
  assign cmdValid = st_q.cmdValid;
  assign cmdByte = st_q.cmdByte;
  assign resumeDone = st_q.resumeDone;
  assign abortOp = st_q.abortOp;
  assign writeEnableLatchBitClear = st_q.welClear;
  assign wpLevel = st_q.wpLvl;
  assign busyOut = st_q.busy;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstN);

  property p_dpd_no_cmd;
    (st_q.mode == MODE_DPD) |=> !st_q.cmdValid;
  endproperty
  a_dpd_no_cmd: assert property (p_dpd_no_cmd) else $error("Command decoded in power-down");

  property p_resume_exit;
    (csRise && !pauseAsserted && st_q.mode == MODE_DPD && st_q.armed && st_q.bitMod == 3'h0)
      |=> (st_q.mode == MODE_STANDBY) && st_q.resumeDone;
  endproperty
  a_resume_exit: assert property (p_resume_exit) else $error("Resume did not reach standby");

  property p_resume_abort;
    (csRise && st_q.mode == MODE_DPD && (!st_q.armed || st_q.bitMod != 3'h0))
      |=> (st_q.mode == MODE_DPD) && !st_q.resumeDone;
  endproperty
  a_resume_abort: assert property (p_resume_abort) else $error("Bad resume left power-down");

  property p_id_msb;
    (active && sckFall && st_q.idPhase && st_q.idIdx == FDRHC_ID_MSB && !csRise)
      |=> st_q.soOut == DEV_ID[7] ##1 st_q.soOe || st_q.hold || pinLvl.csN;
  endproperty
  a_id_msb: assert property (p_id_msb) else $error("Identifier not MSB first");

  property p_id_wrap;
    (active && sckFall && st_q.idPhase && st_q.idIdx == 3'h0 && !csRise)
      |=> st_q.idIdx == FDRHC_ID_MSB && st_q.soOut == DEV_ID[0];
  endproperty
  a_id_wrap: assert property (p_id_wrap) else $error("Identifier did not wrap to bit 7");

  property p_standby_stays;
    (st_q.mode == MODE_STANDBY && csRise) |=> st_q.mode == MODE_STANDBY;
  endproperty
  a_standby_stays: assert property (p_standby_stays) else $error("Standby read changed mode");

  property p_quad_no_hold;
    quadEnableBit |=> !st_q.hold;
  endproperty
  a_quad_no_hold: assert property (p_quad_no_hold) else $error("Pause active in quad mode");

  property p_hold_defer;
    (!pinLvl.csN && pinLvl.sck && !st_q.hold) |=> !st_q.hold;
  endproperty
  a_hold_defer: assert property (p_hold_defer) else $error("Pause entered in clock high");

  property p_hold_float;
    st_q.hold |-> !st_q.soOe && $stable(st_q.bitMod);
  endproperty
  a_hold_float: assert property (p_hold_float) else $error("Output or count moved in pause");

  property p_hold_release;
    (st_q.hold && pinLvl.sck && !pinLvl.csN && !quadEnableBit) |=> st_q.hold;
  endproperty
  a_hold_release: assert property (p_hold_release) else $error("Pause left in clock high");

  property p_abort_wel;
    (csRise && pauseAsserted) |=> st_q.welClear && st_q.abortOp ##1 !st_q.welClear;
  endproperty
  a_abort_wel: assert property (p_abort_wel) else $error("Abort did not clear latch once");

  property p_cs_float;
    csRise |=> !st_q.soOe;
  endproperty
  a_cs_float: assert property (p_cs_float) else $error("Output still driven after deselect");

  // Armed resume survives extra bytes; only deselect may drop it
  property p_resume_ignore;
    (st_q.mode == MODE_DPD && st_q.armed && !csRise) |=> st_q.armed;
  endproperty
  a_resume_ignore: assert property (p_resume_ignore) else $error("Resume lost");

  // Pause entry and pin release both need a sampled clock low phase; deselect clears it at once
  property p_hold_enter;
    (!pinLvl.csN && !pinLvl.sck && pauseAsserted) |=> st_q.hold;
  endproperty
  a_hold_enter: assert property (p_hold_enter) else $error("Pause not entered");

  property p_hold_exit;
    (st_q.hold && !pinLvl.sck && !pauseAsserted) |=> !st_q.hold;
  endproperty
  a_hold_exit: assert property (p_hold_exit) else $error("Pause not left");

  property p_cs_no_hold;
    pinLvl.csN |=> !st_q.hold;
  endproperty
  a_cs_no_hold: assert property (p_cs_no_hold) else $error("Pause while deselected");

  // Protect and busy levels must keep flowing while paused
  property p_hold_wp;
    st_q.hold |-> st_q.wpLvl == $past(pinLvl.wpN);
  endproperty
  a_hold_wp: assert property (p_hold_wp) else $error("Protect frozen in pause");

  property p_hold_busy;
    st_q.hold |-> st_q.busy == $past(busyIn);
  endproperty
  a_hold_busy: assert property (p_hold_busy) else $error("Busy frozen in pause");

  // Abort cancels a pending resume, so the mode must not move
  property p_abort_keeps;
    (csRise && pauseAsserted) |=> !st_q.resumeDone && st_q.mode == $past(st_q.mode);
  endproperty
  a_abort_keeps: assert property (p_abort_keeps) else $error("Abort changed mode");

  c_resume: cover property (st_q.mode == MODE_DPD ##1 st_q.resumeDone);
  c_id_wrap: cover property (st_q.idPhase && st_q.idIdx == 3'h0 ##[1:40] st_q.idIdx == 3'h7);
  c_hold: cover property (st_q.hold ##1 !st_q.hold && !pinLvl.csN);
  c_abort: cover property (st_q.abortOp);
  c_id_out: cover property (st_q.soOe && !st_q.hold);

endmodule : flash_dpd_resume_hold_ctrl
`default_nettype wire

// ---- dv/fdrhc_host_model.sv ----
// Behavioural host controller driving the serial pins of the block
`timescale 1ns/1ps
`default_nettype none
module fdrhc_host_model
  import fdrhc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic soOut,
  input wire logic soOe,
  output fdrhc_pins_t pins
);
  // Idle: deselected, pause and protect released, mode 0 clock parked low
  initial pins = '{csN: 1'b1, pauseN: 1'b1, wpN: 1'b1, sck: 1'b0, si: 1'b0};

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  // One bit: data set in the low phase, output taken late in the high phase
  task automatic bit1(input logic b, output logic r);
    pins.si <= b;
    tick(4);
    pins.sck <= 1'b1;
    tick(3);
    @(negedge clk_sys);
    r = soOe ? soOut : 1'bx; // Undriven output never passes as data
    tick(1);
    pins.sck <= 1'b0;
  endtask : bit1

  // Whole byte, most significant bit first
  task automatic byte8(input logic [7:0] d, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      bit1(d[i], r[i]);
    end
  endtask : byte8

  // Chip select; a released data line shows the inverse of its last bit
  task automatic sel(input logic v);
    tick(1);
    pins.csN <= v;
    if (v) begin
      pins.si <= ~pins.si;
    end
    tick(10);
  endtask : sel

  task automatic set_sck(input logic v);
    tick(1);
    pins.sck <= v;
    tick(10);
  endtask : set_sck

  task automatic set_pause(input logic v);
    tick(1);
    pins.pauseN <= v;
    tick(10);
  endtask : set_pause

  task automatic set_wp(input logic v);
    tick(1);
    pins.wpN <= v;
    tick(10);
  endtask : set_wp

  // Deselected wait of 20 us after a resume before the next command
  task automatic recover();
    tick(800);
  endtask : recover
endmodule : fdrhc_host_model
`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking bench for the power-down resume and pause-pin block
`timescale 1ns/1ps
`default_nettype none
module tb
  import fdrhc_pkg::*;
;
  localparam logic [7:0] ID = 8'h3c; // Arbitrary identifier value
  logic clk_sys, arst_n, qe, qOut, qOe;
  logic busy, dpdReq, soOut, soOe, pOut, pOe, dpd, hold, cmdV;
  logic resDone, abrt, welClr, wpLvl, busyO;
  logic [7:0] cmdB, r, nCmd = 8'h00, nRes = 8'h00, nAbt = 8'h00, nWel = 8'h00;
  fdrhc_pins_t pins;
  int n_mismatch = 0, compares = 0;

  fdrhc_host_model host (.clk_sys(clk_sys), .soOut(soOut), .soOe(soOe), .pins(pins));
  flash_dpd_resume_hold_ctrl #(.DEV_ID(ID)) uut (.clk_sys(clk_sys), .arst_n(arst_n),
    .spiPins(pins), .quadEnableBit(qe), .quadDataOut(qOut), .quadDataOe(qOe),
    .busyIn(busy), .dpdEnterReq(dpdReq), .soOut(soOut), .soOe(soOe), .pausePinOut(pOut),
    .pausePinOe(pOe), .inDeepPowerDown(dpd), .inHold(hold), .cmdValid(cmdV),
    .cmdByte(cmdB), .resumeDone(resDone), .abortOp(abrt),
    .writeEnableLatchBitClear(welClr), .wpLevel(wpLvl), .busyOut(busyO));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Pulse counters, since pulses last one cycle and checks come later
  always @(posedge clk_sys) begin
    if (cmdV === 1'b1) nCmd <= nCmd + 8'h01;
    if (resDone === 1'b1) nRes <= nRes + 8'h01;
    if (abrt === 1'b1) nAbt <= nAbt + 8'h01;
    if (welClr === 1'b1) nWel <= nWel + 8'h01;
  end

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report

  // Compares sample at the falling edge, clear of register updates,
  // then realign to a rising edge so the next drive lands on it
  task automatic chk1(input string what, input logic exp, input logic got);
    @(negedge clk_sys);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
    @(posedge clk_sys);
  endtask : chk1

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    @(negedge clk_sys);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
    @(posedge clk_sys);
  endtask : chk8

  task automatic frame(input logic [7:0] b);
    host.sel(1'b0);
    host.byte8(b, r);
    host.sel(1'b1);
  endtask : frame

  task automatic enter_dpd();
    @(posedge clk_sys) dpdReq <= 1'b1;
    @(posedge clk_sys) dpdReq <= 1'b0;
    host.tick(3);
    chk1("powerdown", 1'b1, dpd);
  endtask : enter_dpd

  task automatic t_dpd(); // Refusals while powered down, then resume
    logic [7:0] c;
    c = nCmd;
    enter_dpd();
    frame(8'h05);
    chk8("ignored cmd", c, nCmd);
    chk1("powerdown", 1'b1, dpd);
    host.sel(1'b0);
    for (int i = 7; i > 0; i--) host.bit1(FDRHC_OP_RESUME[i], r[0]);
    host.sel(1'b1);
    chk1("short opcode", 1'b1, dpd);
    host.sel(1'b0);
    host.byte8(FDRHC_OP_RESUME, r);
    host.bit1(1'b1, r[0]);
    host.sel(1'b1);
    chk1("odd bit count", 1'b1, dpd);
    chk8("no resume", 8'h00, nRes);
    host.sel(1'b0);
    host.byte8(FDRHC_OP_RESUME, r);
    host.byte8(8'hff, r);
    host.sel(1'b1);
    chk1("resumed", 1'b0, dpd);
    chk8("resume pulse", 8'h01, nRes);
    host.recover();
    frame(8'h06);
    chk8("cmd after resume", c + 8'h01, nCmd);
    chk8("cmd byte", 8'h06, cmdB);
  endtask : t_dpd

  task automatic t_id(input logic fromDpd);
    logic [7:0] c;
    if (fromDpd) enter_dpd();
    host.sel(1'b0);
    host.byte8(FDRHC_OP_RESUME, r);
    repeat (3) host.byte8(8'h00, r);
    host.byte8(8'h00, r);
    chk8("id first", ID, r);
    host.byte8(8'h00, r);
    chk8("id repeat", ID, r);
    host.sel(1'b1);
    chk1("out released", 1'b0, soOe);
    chk1("standby", 1'b0, dpd);
    if (fromDpd) chk8("id resume pulse", 8'h02, nRes);
    if (fromDpd) host.recover();
    c = nCmd;
    frame(8'h07);
    chk8("cmd at once", c + 8'h01, nCmd);
  endtask : t_id

  task automatic t_id_hold(); // Pause in mid identifier
    host.sel(1'b0);
    host.byte8(FDRHC_OP_RESUME, r);
    repeat (3) host.byte8(8'h00, r);
    for (int i = 7; i > 3; i--) host.bit1(1'b0, r[i]);
    host.set_pause(1'b0);
    chk1("hold", 1'b1, hold);
    chk1("out floats", 1'b0, soOe);
    host.set_sck(1'b1);
    host.set_sck(1'b0);
    host.set_pause(1'b1);
    chk1("hold left", 1'b0, hold);
    for (int i = 3; i >= 0; i--) host.bit1(1'b0, r[i]);
    chk8("id across pause", ID, r);
    host.sel(1'b1);
  endtask : t_id_hold

  task automatic t_defer(); // Pause edges in clock high phase wait for low
    host.sel(1'b0);
    host.set_sck(1'b1);
    host.set_pause(1'b0);
    chk1("no hold high", 1'b0, hold);
    host.set_sck(1'b0);
    chk1("hold at low", 1'b1, hold);
    host.set_wp(1'b0);
    chk1("protect in hold", 1'b0, wpLvl);
    @(posedge clk_sys) busy <= 1'b1;
    host.tick(2);
    chk1("busy runs", 1'b1, busyO);
    host.set_sck(1'b1);
    host.set_pause(1'b1);
    chk1("still held", 1'b1, hold);
    host.set_sck(1'b0);
    chk1("released", 1'b0, hold);
    host.set_pause(1'b0);
    host.sel(1'b1);
    chk8("abort", 8'h01, nAbt);
    chk8("latch clear", 8'h01, nWel);
    chk1("no hold deselected", 1'b0, hold);
    host.set_pause(1'b1);
    host.set_wp(1'b1);
    @(posedge clk_sys) busy <= 1'b0;
  endtask : t_defer

  task automatic t_quad(); // Pause pin turns data pin
    @(posedge clk_sys) qe <= 1'b1;
    host.sel(1'b0);
    host.set_pause(1'b0);
    chk1("no hold quad", 1'b0, hold);
    host.set_pause(1'b1);
    @(posedge clk_sys) qOut <= 1'b1;
    qOe <= 1'b1;
    host.tick(3);
    chk1("pin enable", 1'b1, pOe);
    chk1("pin data", 1'b1, pOut);
    @(posedge clk_sys) qOut <= 1'b0;
    host.tick(3);
    chk1("pin data low", 1'b0, pOut);
    @(posedge clk_sys) qe <= 1'b0;
    host.tick(3);
    chk1("pin off quad clear", 1'b0, pOe);
    @(posedge clk_sys) qOe <= 1'b0;
    host.sel(1'b1);
  endtask : t_quad

  initial begin
    repeat (100000) @(posedge clk_sys);
    n_mismatch++;
    final_report();
  end

  initial begin
    arst_n <= 1'b0;
    qe <= 1'b0;
    qOut <= 1'b0;
    qOe <= 1'b0;
    busy <= 1'b0;
    dpdReq <= 1'b0;
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    host.tick(10);
    chk1("reset powerdown", 1'b0, dpd);
    chk1("reset protect", 1'b1, wpLvl);
    $display("test reset done");
    t_dpd();
    $display("test powerdown done");
    t_id(1'b1);
    $display("test identifier resume done");
    t_id(1'b0);
    $display("test identifier standby done");
    t_id_hold();
    $display("test identifier pause done");
    t_defer();
    $display("test pause done");
    t_quad();
    $display("test quad done");
    final_report();
  end
endmodule : tb
`default_nettype wire
